// *** shared/nfc_pkg.sv ***
// Purpose: shared constants and types of the NOR flash host controller
// Assumes: 10 MHz hclk, x16 flash with 21 address lines
// Notes:   register offsets are byte addresses on the AHB-Lite slave
package nfc_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int PROG_MAX_NS   = 10000;
   // longest time rounds down
   localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;
   localparam logic [7:0] PROG_MAX_CNT = 8'(PROG_MAX_CYC);
   // cycles before the ready/busy pin is trusted
   localparam logic [7:0] BUSY_GUARD   = 8'h02;

   // register map
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CONFIG = 8'h14;

   // status and config bit positions
   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_ERASING = 4;
   localparam int ST_SUSPEND = 5;
   localparam int ST_RDY     = 6;
   localparam int ST_WP      = 7;
   localparam int CFG_WP     = 0;
   localparam logic CFG_WP_RESET = 1'b1;

   // device command codes and unlock pattern
   localparam logic [15:0] CMD_SECT    = 16'h0050;
   localparam logic [15:0] CMD_BLOCK   = 16'h0030;
   localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
   localparam logic [15:0] CMD_RESUME  = 16'h0030;
   localparam logic [15:0] CMD_PROG    = 16'h00a0;
   localparam logic [15:0] CMD_ERASE   = 16'h0080;
   localparam logic [15:0] UNLOCK_D1   = 16'h00aa;
   localparam logic [15:0] UNLOCK_D2   = 16'h0055;
   localparam logic [20:0] UNLOCK_A1   = 21'h000555;
   localparam logic [20:0] UNLOCK_A2   = 21'h0002aa;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   typedef enum logic [2:0] {
      OP_READ   = 3'h0,
      OP_PROG   = 3'h1,
      OP_SECT   = 3'h2,
      OP_BLOCK  = 3'h3,
      OP_SUSP   = 3'h4,
      OP_RESUME = 3'h5
   } nfc_op_type;

   // one bus cycle towards the flash
   typedef struct packed {
      logic        write;
      logic [20:0] addr;
      logic [15:0] data;
   } nfc_cyc_type;

   // flash pins driven by the host
   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic [20:0] addr;
      logic [15:0] dq_o;
      logic        dq_oe;
   } nfc_pins_type;

   function automatic logic [2:0] seq_len(input nfc_op_type op);
      case (op)
         OP_PROG:  seq_len = 3'd4;
         OP_SECT,
         OP_BLOCK: seq_len = 3'd6;
         default:  seq_len = 3'd1;
      endcase
   endfunction

   // idx-th bus cycle of the sequence for op
   function automatic nfc_cyc_type seq_cycle(input nfc_op_type op,
      input logic [2:0] idx, input logic [20:0] a, input logic [15:0] d);
      nfc_cyc_type c;
      logic [15:0] last;
      c.write = 1'b1;
      c.addr  = UNLOCK_A1;
      c.data  = UNLOCK_D1;
      last    = (op == OP_SECT) ? CMD_SECT : CMD_BLOCK;
      case (op)
         OP_READ: begin
            c.write = 1'b0;
            c.addr  = a;
         end
         OP_SUSP: begin
            c.addr = a;
            c.data = CMD_SUSPEND;
         end
         OP_RESUME: begin
            c.addr = a;
            c.data = CMD_RESUME;
         end
         default: begin
            if (idx == 3'd1 || idx == 3'd4) begin
               c.addr = UNLOCK_A2;
               c.data = UNLOCK_D2;
            end else if (idx == 3'd2) begin
               c.data = (op == OP_PROG) ? CMD_PROG : CMD_ERASE;
            end else if (idx == 3'd3 && op == OP_PROG) begin
               c.addr = a;
               c.data = d;
            end else if (idx == 3'd5) begin
               c.addr = a;
               c.data = last;
            end
         end
      endcase
      return c;
   endfunction

endpackage

// *** hw/nfc_bus_cycle.sv ***
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: flash inputs are synchronous to hclk
// Notes:   strobe is low for two cycles, 200 ns
`timescale 1ns/1ps
module nfc_bus_cycle
   import nfc_pkg::*;
(
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // request side
   input  wire logic         req_valid,
   input  wire nfc_cyc_type  req,
   output      logic         done,
   output      logic [15:0]  rdata,
   // flash pins
   output      nfc_pins_type pins,
   input  wire logic [15:0]  dq_i
);

   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_SETUP = 5'b00010,
      S_PULSE = 5'b00100,
      S_HOLD  = 5'b01000,
      S_END   = 5'b10000
   } nfc_cyc_state_type;

   localparam nfc_pins_type PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1,
      oe_n: 1'b1, addr: 21'h000000, dq_o: 16'h0000, dq_oe: 1'b0};

   nfc_cyc_state_type st_q, st_d;
   nfc_pins_type      pins_q, pins_d;
   logic              write_q, write_d;
   logic              done_q, done_d;
   logic [15:0]       rdata_q, rdata_d;

   always_comb begin
      st_d    = st_q;
      pins_d  = pins_q;
      write_d = write_q;
      done_d  = 1'b0;
      rdata_d = rdata_q;
      case (st_q)
         S_IDLE: begin
            if (req_valid) begin
               // address and data settle before any strobe falls
               write_d      = req.write;
               pins_d.ce_n  = 1'b0;
               pins_d.addr  = req.addr;
               pins_d.dq_o  = req.data;
               pins_d.dq_oe = req.write;
               st_d         = S_SETUP;
            end
         end
         S_SETUP: begin
            pins_d.we_n = ~write_q;
            pins_d.oe_n = write_q;
            st_d        = S_PULSE;
         end
         S_PULSE: st_d = S_HOLD;
         S_HOLD: begin
            // rising we latches data; data stays driven one more cycle
            if (!write_q) begin
               rdata_d = dq_i;
            end
            pins_d.we_n = 1'b1;
            pins_d.oe_n = 1'b1;
            st_d        = S_END;
         end
         S_END: begin
            pins_d.ce_n  = 1'b1;
            pins_d.dq_oe = 1'b0;
            done_d       = 1'b1;
            st_d         = S_IDLE;
         end
         default: begin
            pins_d = PINS_IDLE;
            st_d   = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q    <= S_IDLE;
         pins_q  <= PINS_IDLE;
         write_q <= 1'b0;
         done_q  <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         st_q    <= st_d;
         pins_q  <= pins_d;
         write_q <= write_d;
         done_q  <= done_d;
         rdata_q <= rdata_d;
      end
   end

   assign pins  = pins_q;
   assign done  = done_q;
   assign rdata = rdata_q;

endmodule

// *** hw/nfc_host.sv ***
// Purpose: AHB-Lite controlled host that drives a parallel NOR flash
// Assumes: single-word transfers, flash pins synchronous to hclk
// Notes:   one command at a time; erase runs on while the host is idle
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module nfc_host
   import nfc_pkg::*;
(
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // AHB-Lite slave
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output      logic         hreadyout,
   output      logic [31:0]  hrdata,
   output      logic         hresp,
   // flash pins
   output      nfc_pins_type flash_pins,
   input  wire logic [15:0]  flash_dq_i,
   output      logic         wp_n,
   input  wire logic         ready_busy_n
);

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_CHK  = 4'b0010,
      S_SEQ  = 4'b0100,
      S_WAIT = 4'b1000
   } nfc_state_type;

   // bus slave
   logic        wr_pend_q, wr_pend_d;
   logic [7:0]  wa_q, wa_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic        addr_ph;
   logic        cmd_go;
   nfc_op_type  cmd_op;

   // controller
   nfc_state_type state_q, state_d;
   nfc_op_type    op_q, op_d;
   logic [2:0]    idx_q, idx_d;
   logic [20:0]   addr_q, addr_d;
   logic [15:0]   wdata_q, wdata_d;
   logic [15:0]   rdata_q, rdata_d;
   logic [7:0]    cnt_q, cnt_d;
   logic          done_q, done_d;
   logic          refused_q, refused_d;
   logic          timeout_q, timeout_d;
   logic          erasing_q, erasing_d;
   logic          susp_q, susp_d;
   logic          wp_cfg_q, wp_cfg_d;
   logic          wp_q, wp_d;
   logic          req_q, req_d;
   nfc_cyc_type   cyc_q, cyc_d;
   logic          accept;
   logic          eng_done;
   logic [15:0]   eng_rdata;
   logic [7:0]    status;

   assign addr_ph = hsel & hready & htrans[1];
   assign cmd_go  = wr_pend_q & (wa_q == REG_CMD);
   assign cmd_op  = nfc_op_type'(hwdata[2:0]);
   assign status  = {wp_q, ready_busy_n, susp_q, erasing_q, timeout_q,
                     refused_q, done_q, (state_q != S_IDLE)};

   // bus slave: zero wait states, read data registered in address phase
   always_comb begin
      wr_pend_d = addr_ph & hwrite;
      wa_d      = addr_ph ? haddr[7:0] : wa_q;
      hrdata_d  = hrdata_q;
      if (addr_ph && !hwrite) begin
         if (haddr[7:0] == REG_ADDR) begin
            hrdata_d = {11'h000, addr_q};
         end else if (haddr[7:0] == REG_WDATA) begin
            hrdata_d = {16'h0000, wdata_q};
         end else if (haddr[7:0] == REG_RDATA) begin
            hrdata_d = {16'h0000, rdata_q};
         end else if (haddr[7:0] == REG_STATUS) begin
            hrdata_d = {24'h000000, status};
         end else if (haddr[7:0] == REG_CONFIG) begin
            hrdata_d = {31'h00000000, wp_cfg_q};
         end else begin
            hrdata_d = 32'h00000000;
         end
      end
   end

   // which commands the flash can take in its present condition
   always_comb begin
      if (erasing_q && !susp_q) begin
         accept = (cmd_op == OP_SUSP);
      end else if (susp_q) begin
         // no second erase while one is parked
         accept = (cmd_op == OP_READ) || (cmd_op == OP_PROG) ||
                  (cmd_op == OP_RESUME);
      end else begin
         accept = (cmd_op == OP_READ) || (cmd_op == OP_PROG) ||
                  (cmd_op == OP_SECT) || (cmd_op == OP_BLOCK);
      end
   end

   always_comb begin
      state_d   = state_q;
      op_d      = op_q;
      idx_d     = idx_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      rdata_d   = rdata_q;
      cnt_d     = cnt_q;
      done_d    = done_q;
      refused_d = refused_q;
      timeout_d = timeout_q;
      erasing_d = erasing_q;
      susp_d    = susp_q;
      wp_cfg_d  = wp_cfg_q;
      wp_d      = wp_q;
      req_d     = 1'b0;
      cyc_d     = cyc_q;
      if (wr_pend_q && state_q == S_IDLE) begin
         if (wa_q == REG_ADDR) begin
            addr_d = hwdata[20:0];
         end else if (wa_q == REG_WDATA) begin
            wdata_d = hwdata[15:0];
         end else if (wa_q == REG_CONFIG) begin
            wp_cfg_d = hwdata[CFG_WP];
         end
      end
      case (state_q)
         S_IDLE: begin
            if (erasing_q && !susp_q && ready_busy_n) begin
               erasing_d = 1'b0;
            end
            if (!cmd_go) begin
               wp_d = wp_cfg_q;
            end else if (!accept) begin
               refused_d = 1'b1;
               done_d    = 1'b1;
            end else begin
               done_d    = 1'b0;
               refused_d = 1'b0;
               timeout_d = 1'b0;
               op_d      = cmd_op;
               idx_d     = 3'd0;
               req_d     = 1'b1;
               if (cmd_op == OP_PROG) begin
                  // look at the target word before touching it
                  cyc_d   = seq_cycle(OP_READ, 3'd0, addr_q, wdata_q);
                  state_d = S_CHK;
               end else begin
                  cyc_d   = seq_cycle(cmd_op, 3'd0, addr_q, wdata_q);
                  state_d = S_SEQ;
               end
            end
         end
         S_CHK: begin
            if (eng_done) begin
               if (eng_rdata == ERASED_WORD) begin
                  req_d   = 1'b1;
                  cyc_d   = seq_cycle(op_q, 3'd0, addr_q, wdata_q);
                  state_d = S_SEQ;
               end else begin
                  refused_d = 1'b1;
                  done_d    = 1'b1;
                  state_d   = S_IDLE;
               end
            end
         end
         S_SEQ: begin
            if (eng_done) begin
               if (op_q == OP_READ) begin
                  rdata_d = eng_rdata;
                  done_d  = 1'b1;
                  state_d = S_IDLE;
               end else if (idx_q == seq_len(op_q) - 3'd1) begin
                  cnt_d = 8'h00;
                  if (op_q == OP_SECT || op_q == OP_BLOCK) begin
                     erasing_d = 1'b1;
                     done_d    = 1'b1;
                     state_d   = S_IDLE;
                  end else if (op_q == OP_RESUME) begin
                     susp_d  = 1'b0;
                     done_d  = 1'b1;
                     state_d = S_IDLE;
                  end else begin
                     state_d = S_WAIT;
                  end
               end else begin
                  idx_d = idx_q + 3'd1;
                  req_d = 1'b1;
                  cyc_d = seq_cycle(op_q, idx_q + 3'd1, addr_q, wdata_q);
               end
            end
         end
         S_WAIT: begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q >= BUSY_GUARD && ready_busy_n) begin
               done_d  = 1'b1;
               susp_d  = susp_q | (op_q == OP_SUSP);
               state_d = S_IDLE;
            end else if (op_q == OP_PROG && cnt_q >= PROG_MAX_CNT) begin
               // device overran its program bound; give the bus back
               timeout_d = 1'b1;
               done_d    = 1'b1;
               state_d   = S_IDLE;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wa_q      <= 8'h00;
         hrdata_q  <= 32'h00000000;
         state_q   <= S_IDLE;
         op_q      <= OP_READ;
         idx_q     <= 3'd0;
         addr_q    <= 21'h000000;
         wdata_q   <= 16'h0000;
         rdata_q   <= 16'h0000;
         cnt_q     <= 8'h00;
         done_q    <= 1'b0;
         refused_q <= 1'b0;
         timeout_q <= 1'b0;
         erasing_q <= 1'b0;
         susp_q    <= 1'b0;
         wp_cfg_q  <= CFG_WP_RESET;
         wp_q      <= CFG_WP_RESET;
         req_q     <= 1'b0;
         cyc_q     <= '0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wa_q      <= wa_d;
         hrdata_q  <= hrdata_d;
         state_q   <= state_d;
         op_q      <= op_d;
         idx_q     <= idx_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         rdata_q   <= rdata_d;
         cnt_q     <= cnt_d;
         done_q    <= done_d;
         refused_q <= refused_d;
         timeout_q <= timeout_d;
         erasing_q <= erasing_d;
         susp_q    <= susp_d;
         wp_cfg_q  <= wp_cfg_d;
         wp_q      <= wp_d;
         req_q     <= req_d;
         cyc_q     <= cyc_d;
      end
   end

   nfc_bus_cycle u_cycle (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .req_valid (req_q),
      .req       (cyc_q),
      .done      (eng_done),
      .rdata     (eng_rdata),
      .pins      (flash_pins),
      .dq_i      (flash_dq_i)
   );

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign wp_n      = wp_q;

   // checks
   logic [2:0] wr_cnt_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_cnt_q <= 3'd0;
      end else if (state_q == S_IDLE) begin
         wr_cnt_q <= 3'd0;
      end else if (req_q && cyc_q.write) begin
         wr_cnt_q <= wr_cnt_q + 3'd1;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_we_rise;
      !flash_pins.we_n ##1 flash_pins.we_n;
   endsequence

   a_we_in_ce: assert property (
      !flash_pins.we_n |-> !flash_pins.ce_n)
      else $error("we low without ce low");
   a_we_pulse_shape: assert property (
      $fell(flash_pins.we_n) |=> s_we_rise)
      else $error("write strobe not two cycles");
   a_wp_steady: assert property (
      state_q != S_IDLE |-> $stable(wp_n))
      else $error("write protect moved in a sequence");
   a_prog_unerased: assert property (
      (state_q == S_CHK && eng_done && eng_rdata != ERASED_WORD)
      |=> state_q == S_IDLE && refused_q && !req_q)
      else $error("program of an unerased word");
   a_prog_four_writes: assert property (
      (state_q == S_SEQ && state_d == S_WAIT && op_q == OP_PROG)
      |-> wr_cnt_q == 3'd4)
      else $error("program sequence not four writes");
   a_sector_last_code: assert property (
      (req_q && op_q == OP_SECT && idx_q == 3'd5)
      |-> cyc_q.data == CMD_SECT && cyc_q.addr == addr_q)
      else $error("sector erase last cycle wrong");
   a_block_last_code: assert property (
      (req_q && op_q == OP_BLOCK && idx_q == 3'd5)
      |-> cyc_q.data == CMD_BLOCK && cyc_q.addr == addr_q)
      else $error("block erase last cycle wrong");
   a_erase_six_writes: assert property (
      $rose(erasing_q) |-> wr_cnt_q == 3'd6)
      else $error("erase sequence not six writes");

endmodule

// *** test/nfc_flash_model.sv ***
// Purpose: behavioural parallel NOR flash facing the host bench
// Assumes: bottom boot map unless TOP_BOOT, pins move on hclk
// Notes:   busy times are short stand-ins, not device figures
`timescale 1ns/1ps
module nfc_flash_model
   import nfc_pkg::*;
#(
   parameter int PROG_NS  = 5000,
   parameter int ERASE_NS = 30000,
   parameter bit TOP_BOOT = 1'b0
)(
   // host side
   input  wire logic         wp_n,
   input  wire nfc_pins_type pins,
   input  wire logic [15:0]  bus_dq,
   // device side
   output      logic [15:0]  read_dq,
   output      logic         pull_low,
   output      int           viol
);
   logic [15:0] mem [int];
   logic [20:0] a_lat, er_a;
   logic [15:0] p_d, last = '0;
   int          step, pl, el, sw;
   logic        prog, ers, susp, sect, tog;
   logic        armed = 1'b0, nap = 1'b0;

   function automatic logic [15:0] get(input logic [20:0] a);
      return mem.exists(a) ? mem[a] : ERASED_WORD;
   endfunction
   function automatic logic [20:0] base(input logic [20:0] a, input logic s);
      if (s) return {a[20:11], 11'h0};
      if (TOP_BOOT ? a >= 21'h1f8000 : a < 21'h008000)
         return {a[20:12], 12'h0};
      return {a[20:15], 15'h0};
   endfunction
   function automatic logic guard(input logic [20:0] a);
      // two boot blocks at the protected end
      return !wp_n && (TOP_BOOT ? a >= 21'h1fe000 : a < 21'h002000);
   endfunction
   task automatic wipe;
      int ks[$];
      foreach (mem[k]) if (base(21'(k), sect) == er_a) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
      ers = 1'b0;
   endtask
   task automatic start_prog(input logic [20:0] a, input logic [15:0] d);
      if (guard(a) || (susp && base(a, sect) == er_a))
         return;
      if (get(a) !== ERASED_WORD)
         viol++;
      mem[a] = d;
      p_d = d;
      prog = 1'b1;
      pl = PROG_NS / 100;
   endtask
   task automatic start_erase(input logic [20:0] a, input logic [15:0] d);
      if (guard(a) || susp || !(d == CMD_SECT || d == CMD_BLOCK))
         return;
      sect = (d == CMD_SECT);
      er_a = base(a, sect);
      el = ERASE_NS / 100;
      ers = 1'b1;
   endtask
   task automatic cmd(input logic [20:0] a, input logic [15:0] d);
      if (prog || (ers && !susp && d !== CMD_SUSPEND))
         step = 0;
      else if (ers && !susp) begin
         susp = 1'b1;
         sw = 3;
      end else if (susp && step == 0 && d === CMD_RESUME)
         susp = 1'b0;
      else
         case (step)
            0, 5: step = (a == UNLOCK_A1 && d == UNLOCK_D1) ? step + 1 : 0;
            1, 6: step = (a == UNLOCK_A2 && d == UNLOCK_D2) ? step + 1 : 0;
            2: step = (a != UNLOCK_A1) ? 0 : (d == CMD_PROG) ? 3 :
                      (d == CMD_ERASE) ? 5 : 0;
            3: begin
               step = 0;
               start_prog(a, d);
            end
            7: begin
               step = 0;
               start_erase(a, d);
            end
            default: step = 0;
         endcase
   endtask

   initial begin
      {prog, ers, susp, tog} = '0;
      forever begin
         #100;
         if (sw > 0) sw--;
         if (pl == 1) prog = 1'b0;
         if (pl > 0) pl--;
         if (ers && !susp && el == 1) wipe();
         if (ers && !susp && el > 0) el--;
      end
   end

   // open drain: the bench supplies the pull-up
   assign pull_low = prog || (ers && !(susp && sw == 0));
   always @(negedge pins.we_n or negedge pins.ce_n)
      if (!pins.we_n && !pins.ce_n) a_lat = pins.addr;
   always @(posedge pins.we_n or posedge pins.ce_n)
      if (pins.we_n != pins.ce_n) cmd(a_lat, bus_dq);
   always @(negedge pins.oe_n) begin
      tog = ~tog;
      nap = 1'b0;
   end
   // low power after a read, never before the first address move or
   // deselect; read data ignores nap, so waking costs nothing
   always @(pins.addr or posedge pins.ce_n) begin
      armed = 1'b1;
      nap = 1'b0;
   end
   always @(posedge pins.oe_n) if (!pins.ce_n) nap = armed;
   // protect level must not move inside a command sequence
   always @(wp_n) if (step != 0) viol++;
   always @* begin
      if (!pins.ce_n && !pins.oe_n) begin
         if (prog) read_dq = {8'h0, ~p_d[7], tog, 6'h0};
         else if (ers && !susp) read_dq = {8'h0, 1'b0, tog, 3'h0, tog, 2'h0};
         else if (ers && base(pins.addr, sect) == er_a)
            read_dq = {8'h0, 2'b11, 3'h0, tog, 2'h0};
         else read_dq = get(pins.addr);
         last = read_dq;
      end else read_dq = ~last;
   end
endmodule

// *** test/testbench.sv ***
// Purpose: self-checking bench of the NOR flash host controller
// Assumes: flash model on the pins, AHB-Lite master tasks here
// Notes:   model busy times are shortened
`timescale 1ns/1ps
module testbench;
   import nfc_pkg::*;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic         wp_n, pull_low;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic [31:0]  haddr, hwdata, hrdata, s;
   logic [15:0]  read_dq;
   nfc_pins_type flash_pins;
   int           viol, miscompares, comparisons, busy_seen;
   wire          ready_busy_n = !pull_low;
   wire [15:0]   bus_dq = flash_pins.dq_oe ? flash_pins.dq_o : read_dq;

   nfc_host nfc_host_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .flash_pins(flash_pins), .flash_dq_i(bus_dq),
      .wp_n(wp_n), .ready_busy_n(ready_busy_n));
   nfc_flash_model nfc_flash_model_inst (
      .wp_n(wp_n), .pins(flash_pins), .bus_dq(bus_dq),
      .read_dq(read_dq), .pull_low(pull_low), .viol(viol));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   always @(negedge ready_busy_n) busy_seen++;

   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      s = hrdata;
      // idle cycle so a read-back sees the write
      @(posedge hclk);
   endtask
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         ahb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (s[b] !== 1'b0 && n < 3000);
      if (s[b] !== 1'b0) begin
         miscompares++;
         $display("unexpected at %0t: poll limit reached", $time);
      end
   endtask
   task automatic op(input nfc_op_type c);
      ahb(1'b1, REG_CMD, 32'(c));
      poll(ST_BUSY);
   endtask
   task automatic prog(input logic [20:0] a, input logic [15:0] d);
      ahb(1'b1, REG_ADDR, 32'(a));
      ahb(1'b1, REG_WDATA, 32'(d));
      op(OP_PROG);
   endtask
   task automatic fread(input logic [20:0] a);
      ahb(1'b1, REG_ADDR, 32'(a));
      op(OP_READ);
      ahb(1'b0, REG_RDATA, 32'h0);
   endtask
   task automatic erase(input nfc_op_type c, input logic [20:0] a);
      ahb(1'b1, REG_ADDR, 32'(a));
      op(c);
      poll(ST_ERASING);
   endtask

   task automatic t_reset;
      ahb(1'b0, REG_STATUS, 32'h0);
      check(s, 32'h0000_00c0);
      ahb(1'b0, REG_CONFIG, 32'h0);
      check(s, 32'h1);
      ahb(1'b1, 8'h40, 32'h1234_5678);
      ahb(1'b0, 8'h40, 32'h0);
      check(s, 32'h0);
      ahb(1'b1, REG_ADDR, 32'hffff_ffff);
      ahb(1'b0, REG_ADDR, 32'h0);
      check(s, 32'h001f_ffff);
      check(32'(hresp), 32'h0);
      $display("reset test done");
   endtask
   task automatic t_prog;
      prog(21'h010123, 16'h5aa5);
      check(s & 32'hf, 32'h2);
      check(32'(busy_seen > 0), 32'h1);
      fread(21'h010123);
      check(s, 32'h5aa5);
      prog(21'h010123, 16'h0000);
      check(s & 32'hf, 32'h6);
      op(nfc_op_type'(3'h7));
      check(s & 32'hf, 32'h6);
      $display("program test done");
   endtask
   task automatic t_erase;
      logic [31:0] t;
      prog(21'h010900, 16'h1234);
      ahb(1'b1, REG_ADDR, 32'h0001_0100);
      op(OP_SECT);
      check(s & 32'h13, 32'h12);
      op(OP_PROG);
      check(s & 32'h6, 32'h6);
      op(OP_SUSP);
      check(s & 32'h30, 32'h30);
      fread(21'h010123);
      t = s;
      check(s & 32'hc0, 32'hc0);
      fread(21'h010123);
      check((s ^ t) & 32'h4, 32'h4);
      fread(21'h010900);
      check(s, 32'h1234);
      prog(21'h011000, 16'h00ff);
      check(s & 32'h6, 32'h2);
      op(OP_RESUME);
      check(s & 32'h30, 32'h10);
      poll(ST_ERASING);
      fread(21'h010123);
      check(s, 32'hffff);
      fread(21'h011000);
      check(s, 32'h00ff);
      $display("erase test done");
   endtask
   task automatic t_block;
      prog(21'h007010, 16'h0a0a);
      prog(21'h006ff0, 16'h0b0b);
      prog(21'h008000, 16'h0c0c);
      erase(OP_BLOCK, 21'h007000);
      fread(21'h007010);
      check(s, 32'hffff);
      fread(21'h006ff0);
      check(s, 32'h0b0b);
      fread(21'h008000);
      check(s, 32'h0c0c);
      erase(OP_BLOCK, 21'h00f000);
      fread(21'h008000);
      check(s, 32'hffff);
      $display("block test done");
   endtask
   task automatic t_protect;
      prog(21'h000010, 16'h1111);
      ahb(1'b1, REG_CONFIG, 32'h0);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(s & 32'h80, 32'h0);
      check(32'(wp_n), 32'h0);
      prog(21'h001000, 16'h0abc);
      fread(21'h001000);
      check(s, 32'hffff);
      erase(OP_BLOCK, 21'h000000);
      fread(21'h000010);
      check(s, 32'h1111);
      ahb(1'b1, REG_CONFIG, 32'h1);
      prog(21'h001000, 16'h0abc);
      fread(21'h001000);
      check(s, 32'h0abc);
      $display("protect test done");
   endtask

   initial begin
      #5_000_000;
      miscompares++;
      results();
   end
   initial begin
      {hresetn, hsel, hwrite, htrans} = '0;
      haddr = '0;
      hwdata = '0;
      hsize = 3'b010;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_prog();
      t_erase();
      t_block();
      t_protect();
      check(32'(viol), 32'h0);
      results();
   end
endmodule
